// ===== rtl/emc_regs_map.svh
// register offsets, field positions, reset values and the secondary write mask of the control register bank
`ifndef EMC_REGS_MAP_SVH
`define EMC_REGS_MAP_SVH

// offsets present in every bank (5-bit register address)
`define EMC_OFF_PRIMARY_CONTROL   5'h1C
`define EMC_OFF_SECONDARY_CONTROL 5'h1D

// banked offsets, written as {bank[1:0], address[4:0]}
`define EMC_OFF_RD_PTR_LOW        7'h00
`define EMC_OFF_RD_PTR_HIGH       7'h01
`define EMC_OFF_WR_PTR_LOW        7'h02
`define EMC_OFF_WR_PTR_HIGH       7'h03
`define EMC_OFF_DATA_PORT         7'h04
`define EMC_OFF_PACKET_COUNT      7'h29
`define EMC_OFF_MGMT_WR_LOW       7'h40
`define EMC_OFF_MGMT_WR_HIGH      7'h41
`define EMC_OFF_MGMT_RD_LOW       7'h42
`define EMC_OFF_MGMT_RD_HIGH      7'h43
`define EMC_OFF_STATION_ADDR0     7'h60
`define EMC_OFF_SELFTEST_SEED     7'h66
`define EMC_OFF_SELFTEST_CTRL     7'h67
`define EMC_OFF_SELFTEST_CS_LOW   7'h68
`define EMC_OFF_SELFTEST_CS_HIGH  7'h69
`define EMC_OFF_MGMT_STATUS       7'h6A
`define EMC_OFF_REVISION          7'h6B
`define EMC_OFF_CLOCK_OUT         7'h6C
`define EMC_OFF_FLOW_CONTROL      7'h6D
`define EMC_OFF_PAUSE_LOW         7'h6E
`define EMC_OFF_PAUSE_HIGH        7'h6F
`define EMC_OFF_CLOCK_STATUS      7'h70

// field positions
`define EMC_BIT_AUTO_INC          7
`define EMC_BIT_PKT_DEC           6
`define EMC_BIT_POWER_SAVE        5
`define EMC_BIT_REG_LOW_CURRENT   3

// reset values and the secondary write mask
`define EMC_RST_PRIMARY           8'h00
`define EMC_RST_SECONDARY         8'h80
`define EMC_RST_CLOCK_OUT         3'h4
`define EMC_RST_PAUSE             16'h1000
`define EMC_MASK_SECONDARY        8'hE8

`endif

// ===== rtl/emc_pkg.sv
// types shared by the control register bank
package emc_pkg;
    typedef struct packed {
        logic       tx_reset;
        logic       rx_reset;
        logic       dma_busy;
        logic       dma_checksum;
        logic       tx_request;
        logic       rx_enable;
        logic [1:0] bank_select;
    } emc_primary_s;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [4:0] addr;
        logic [7:0] wdata;
    } emc_req_s;
endpackage

// ===== rtl/emc_ctrl_regs.sv
// main control and status register bank of the ethernet controller
//
// Operation
// RULE1 - primary bit 7 set holds transmit logic in reset
// RULE2 - primary bit 6 set holds receive logic in reset
// RULE3 - primary bit 5 reads one while a dma operation runs
// RULE4 - primary bit 4 picks checksum (1) or copy (0) dma mode
// RULE5 - primary bit 3 reads one while transmit logic sends a packet
// RULE6 - primary bit 2 set lets filtered packets in, clear drops all
// RULE7 - primary bits 1-0 select register bank 0 to 3
// RULE8 - secondary bit 7 makes data port accesses advance buffer pointers
// RULE9 - writing one to secondary bit 6 lowers packet counter by one
// RULE10 - secondary bit 6 clears itself and reads back zero
// RULE11 - secondary bit 5 puts mac, phy and control logic to sleep
// RULE12 - secondary bit 3 lowers regulator current only during power save
// RULE13 - software writes zero to secondary bit 4
// RULE14 - secondary bits 2-0 always read zero
// RULE15 - clock-out control loads 100 at power-on, kept on other resets
// RULE16 - clock-ready flag clears at power-on, other resets leave it
// RULE17 - revision register is read-only
// RULE18 - host leaves receive buffer bounds alone while reception is on
// RULE19 - primary resets to zero, secondary to auto-increment only
// RULE20 - dma busy and transmit request clear when their engines finish
`timescale 1ns/1ps
`include "emc_regs_map.svh"

module emc_ctrl_regs
    import emc_pkg::*;
#(
    parameter logic [4:0] REVISION_ID = 5'h01  // arbitrary value
) (
    // clock and resets
    input  wire logic        clk_sys_in,
    input  wire logic        rst_in,
    input  wire logic        soft_reset_in,
    // register access port
    input  wire emc_req_s    req_in,
    output logic [7:0]       reg_rdata_out,
    // buffer data port
    input  wire logic [7:0]  buffer_rdata_in,
    output logic             buffer_rd_out,
    output logic             buffer_wr_out,
    output logic [7:0]       buffer_wdata_out,
    output logic [12:0]      buffer_read_pointer_out,
    output logic [12:0]      buffer_write_pointer_out,
    // engine status
    input  wire logic        dma_done_in,
    input  wire logic        tx_done_in,
    input  wire logic        rx_packet_in,
    input  wire logic        rx_filter_pass_in,
    input  wire logic        clock_ready_in,
    input  wire logic [7:0]  mgmt_status_in,
    input  wire logic [15:0] mgmt_read_data_in,
    input  wire logic [15:0] selftest_checksum_in,
    input  wire logic        full_duplex_in,
    // engine controls
    output emc_primary_s     primary_out,
    output logic             rx_store_packet_out,
    output logic             power_save_out,
    output logic             regulator_low_current_out,
    output logic [7:0]       pending_packet_counter_out,
    output logic             mgmt_write_start_out,
    output logic [15:0]      mgmt_write_data_out,
    output logic [47:0]      station_address_out,
    output logic [7:0]       selftest_seed_out,
    output logic [7:0]       selftest_control_out,
    output logic [2:0]       clock_out_control_out,
    output logic [1:0]       flow_control_out,
    output logic [15:0]      pause_timer_out,
    output logic             clock_ready_flag_out
);

    emc_primary_s primary_control;
    logic [7:0]   secondary_control;
    logic [6:0]   full_addr;
    logic         wr_common;
    logic         wr_primary;
    logic         wr_secondary;
    logic         pkt_dec;
    logic         auto_inc;
    logic [7:0]   next_rdata;

    // banked address hit on a write or read
    function automatic logic hit(input logic [6:0] addr, input logic [6:0] off);
        return addr == off;
    endfunction

    // the bank field steers every banked access; common offsets ignore it
    assign full_addr    = {primary_control.bank_select, req_in.addr};  // RULE7
    assign wr_common    = req_in.wr;
    assign wr_primary   = wr_common && req_in.addr == `EMC_OFF_PRIMARY_CONTROL;
    assign wr_secondary = wr_common && req_in.addr == `EMC_OFF_SECONDARY_CONTROL;
    assign pkt_dec      = wr_secondary && req_in.wdata[`EMC_BIT_PKT_DEC];  // RULE9
    assign auto_inc     = secondary_control[`EMC_BIT_AUTO_INC];

    // primary control: reset and dma/transmit status, hardware clears win over nothing
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            primary_control <= emc_primary_s'(`EMC_RST_PRIMARY);  // RULE19
        end else if (soft_reset_in) begin
            primary_control <= emc_primary_s'(`EMC_RST_PRIMARY);  // RULE19
        end else begin
            if (wr_primary) begin
                primary_control <= emc_primary_s'(req_in.wdata);
            end
            // completion in the write cycle still clears a busy bit the host did not set anew
            if (dma_done_in && !(wr_primary && req_in.wdata[5])) begin
                primary_control.dma_busy <= 1'b0;  // RULE20 RULE3
            end
            if ((tx_done_in || primary_control.tx_reset) && !(wr_primary && req_in.wdata[3])) begin
                primary_control.tx_request <= 1'b0;  // RULE20 RULE5
            end
        end
    end

    // secondary control: decrement bit never stored, low bits unimplemented
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            secondary_control <= `EMC_RST_SECONDARY;  // RULE19
        end else if (soft_reset_in) begin
            secondary_control <= `EMC_RST_SECONDARY;
        end else if (wr_secondary) begin
            secondary_control <= req_in.wdata & `EMC_MASK_SECONDARY & ~8'h40;  // RULE10 RULE14
        end
    end

    // engine controls; transmit request is cleared by the transmit reset, packet storing gated by the receive reset
    assign primary_out         = primary_control;  // RULE1 RULE2 RULE4
    assign rx_store_packet_out = rx_packet_in && rx_filter_pass_in && primary_control.rx_enable
                                 && !primary_control.rx_reset;  // RULE6 RULE2
    assign power_save_out      = secondary_control[`EMC_BIT_POWER_SAVE];  // RULE11
    assign regulator_low_current_out = secondary_control[`EMC_BIT_POWER_SAVE]
                                       && secondary_control[`EMC_BIT_REG_LOW_CURRENT];  // RULE12

    // pending packet counter: an arrival and a decrement together cancel out
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            pending_packet_counter_out <= 8'h00;
        end else if (soft_reset_in) begin
            pending_packet_counter_out <= 8'h00;
        end else if (rx_store_packet_out && !pkt_dec) begin
            if (pending_packet_counter_out != 8'hFF) begin
                pending_packet_counter_out <= pending_packet_counter_out + 8'h01;
            end
        end else if (pkt_dec && !rx_store_packet_out) begin
            if (pending_packet_counter_out != 8'h00) begin
                pending_packet_counter_out <= pending_packet_counter_out - 8'h01;  // RULE9
            end
        end
    end

    // data port strobes; pointers move only with auto-increment on
    assign buffer_rd_out    = req_in.rd && hit(full_addr, `EMC_OFF_DATA_PORT);
    assign buffer_wr_out    = req_in.wr && hit(full_addr, `EMC_OFF_DATA_PORT);
    assign buffer_wdata_out = req_in.wdata;

    // buffer pointers, 13 bits covering the 8 kbyte buffer
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            buffer_read_pointer_out  <= 13'h0000;
            buffer_write_pointer_out <= 13'h0000;
        end else if (soft_reset_in) begin
            buffer_read_pointer_out  <= 13'h0000;
            buffer_write_pointer_out <= 13'h0000;
        end else begin
            if (wr_common && hit(full_addr, `EMC_OFF_RD_PTR_LOW)) begin
                buffer_read_pointer_out[7:0] <= req_in.wdata;
            end else if (wr_common && hit(full_addr, `EMC_OFF_RD_PTR_HIGH)) begin
                buffer_read_pointer_out[12:8] <= req_in.wdata[4:0];
            end else if (buffer_rd_out && auto_inc) begin
                buffer_read_pointer_out <= buffer_read_pointer_out + 13'h0001;  // RULE8
            end
            if (wr_common && hit(full_addr, `EMC_OFF_WR_PTR_LOW)) begin
                buffer_write_pointer_out[7:0] <= req_in.wdata;
            end else if (wr_common && hit(full_addr, `EMC_OFF_WR_PTR_HIGH)) begin
                buffer_write_pointer_out[12:8] <= req_in.wdata[4:0];
            end else if (buffer_wr_out && auto_inc) begin
                buffer_write_pointer_out <= buffer_write_pointer_out + 13'h0001;  // RULE8
            end
        end
    end

    // management write data; a write of the high byte starts the transaction
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            mgmt_write_data_out  <= 16'h0000;
            mgmt_write_start_out <= 1'b0;
        end else if (soft_reset_in) begin
            mgmt_write_data_out  <= 16'h0000;
            mgmt_write_start_out <= 1'b0;
        end else begin
            mgmt_write_start_out <= wr_common && hit(full_addr, `EMC_OFF_MGMT_WR_HIGH);
            if (wr_common && hit(full_addr, `EMC_OFF_MGMT_WR_LOW)) begin
                mgmt_write_data_out[7:0] <= req_in.wdata;
            end
            if (wr_common && hit(full_addr, `EMC_OFF_MGMT_WR_HIGH)) begin
                mgmt_write_data_out[15:8] <= req_in.wdata;
            end
        end
    end

    // station address, self-test, flow control and pause timer settings
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            station_address_out  <= 48'h0;
            selftest_seed_out    <= 8'h00;
            selftest_control_out <= 8'h00;
            flow_control_out     <= 2'h0;
            pause_timer_out      <= `EMC_RST_PAUSE;
        end else if (soft_reset_in) begin
            station_address_out  <= 48'h0;
            selftest_seed_out    <= 8'h00;
            selftest_control_out <= 8'h00;
            flow_control_out     <= 2'h0;
            pause_timer_out      <= `EMC_RST_PAUSE;
        end else if (wr_common) begin
            for (int i = 0; i < 6; i++) begin
                if (hit(full_addr, 7'(`EMC_OFF_STATION_ADDR0 + i))) begin
                    station_address_out[8*(5-i) +: 8] <= req_in.wdata;
                end
            end
            if (hit(full_addr, `EMC_OFF_SELFTEST_SEED)) begin
                selftest_seed_out <= req_in.wdata;
            end
            if (hit(full_addr, `EMC_OFF_SELFTEST_CTRL)) begin
                selftest_control_out <= req_in.wdata;
            end
            if (hit(full_addr, `EMC_OFF_FLOW_CONTROL)) begin
                flow_control_out <= req_in.wdata[1:0];
            end
            if (hit(full_addr, `EMC_OFF_PAUSE_LOW)) begin
                pause_timer_out[7:0] <= req_in.wdata;
            end
            if (hit(full_addr, `EMC_OFF_PAUSE_HIGH)) begin
                pause_timer_out[15:8] <= req_in.wdata;
            end
        end
    end

    // clock-out control survives every reset but power-on
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            clock_out_control_out <= `EMC_RST_CLOCK_OUT;  // RULE15
        end else if (wr_common && hit(full_addr, `EMC_OFF_CLOCK_OUT)) begin
            clock_out_control_out <= req_in.wdata[2:0];
        end
    end

    // clock-ready flag, likewise untouched by the soft reset
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            clock_ready_flag_out <= 1'b0;  // RULE16
        end else if (clock_ready_in) begin
            clock_ready_flag_out <= 1'b1;
        end
    end

    // read mux; the revision has no write path at all
    always_comb begin
        next_rdata = 8'h00;
        if (req_in.addr == `EMC_OFF_PRIMARY_CONTROL) begin
            next_rdata = primary_control;
        end else if (req_in.addr == `EMC_OFF_SECONDARY_CONTROL) begin
            next_rdata = secondary_control;  // RULE14 RULE10
        end else begin
            unique case (full_addr)
                `EMC_OFF_RD_PTR_LOW:       next_rdata = buffer_read_pointer_out[7:0];
                `EMC_OFF_RD_PTR_HIGH:      next_rdata = {3'h0, buffer_read_pointer_out[12:8]};
                `EMC_OFF_WR_PTR_LOW:       next_rdata = buffer_write_pointer_out[7:0];
                `EMC_OFF_WR_PTR_HIGH:      next_rdata = {3'h0, buffer_write_pointer_out[12:8]};
                `EMC_OFF_DATA_PORT:        next_rdata = buffer_rdata_in;
                `EMC_OFF_PACKET_COUNT:     next_rdata = pending_packet_counter_out;
                `EMC_OFF_MGMT_WR_LOW:      next_rdata = mgmt_write_data_out[7:0];
                `EMC_OFF_MGMT_WR_HIGH:     next_rdata = mgmt_write_data_out[15:8];
                `EMC_OFF_MGMT_RD_LOW:      next_rdata = mgmt_read_data_in[7:0];
                `EMC_OFF_MGMT_RD_HIGH:     next_rdata = mgmt_read_data_in[15:8];
                `EMC_OFF_SELFTEST_SEED:    next_rdata = selftest_seed_out;
                `EMC_OFF_SELFTEST_CTRL:    next_rdata = selftest_control_out;
                `EMC_OFF_SELFTEST_CS_LOW:  next_rdata = selftest_checksum_in[7:0];
                `EMC_OFF_SELFTEST_CS_HIGH: next_rdata = selftest_checksum_in[15:8];
                `EMC_OFF_MGMT_STATUS:      next_rdata = {4'h0, mgmt_status_in[3:0]};
                `EMC_OFF_REVISION:         next_rdata = {3'h0, REVISION_ID};  // RULE17
                `EMC_OFF_CLOCK_OUT:        next_rdata = {5'h00, clock_out_control_out};
                `EMC_OFF_FLOW_CONTROL:     next_rdata = {5'h00, full_duplex_in, flow_control_out};
                `EMC_OFF_PAUSE_LOW:        next_rdata = pause_timer_out[7:0];
                `EMC_OFF_PAUSE_HIGH:       next_rdata = pause_timer_out[15:8];
                `EMC_OFF_CLOCK_STATUS:     next_rdata = {7'h00, clock_ready_flag_out};
                default: begin
                    for (int i = 0; i < 6; i++) begin
                        if (hit(full_addr, 7'(`EMC_OFF_STATION_ADDR0 + i))) begin
                            next_rdata = station_address_out[8*(5-i) +: 8];
                        end
                    end
                end
            endcase
        end
    end

    // read data is registered, valid the cycle after the read strobe
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            reg_rdata_out <= 8'h00;
        end else if (req_in.rd) begin
            reg_rdata_out <= next_rdata;
        end
    end

    // checks
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in || soft_reset_in);

    a_dma_clears_done: assert property (dma_done_in && !wr_primary |=> !primary_control.dma_busy)  // RULE3
        else $error("dma busy stayed set after completion");
    a_tx_clears_done: assert property (tx_done_in && !wr_primary |=> !primary_out.tx_request)  // RULE5
        else $error("transmit request stayed set after completion");
    a_rx_gate_off: assert property (!primary_control.rx_enable |-> !rx_store_packet_out)  // RULE6
        else $error("packet stored with reception disabled");
    a_auto_inc_read: assert property (buffer_rd_out && auto_inc && !wr_common
                                      |=> buffer_read_pointer_out == $past(buffer_read_pointer_out) + 13'h0001)  // RULE8
        else $error("read pointer did not advance");
    a_no_inc_held: assert property (buffer_wr_out && !auto_inc
                                    |=> $stable(buffer_write_pointer_out))  // RULE8
        else $error("write pointer moved without auto-increment");
    a_pkt_dec_one: assert property (pkt_dec && !rx_store_packet_out && pending_packet_counter_out != 8'h00
                                    |=> pending_packet_counter_out == $past(pending_packet_counter_out) - 8'h01)  // RULE9
        else $error("packet counter not decremented by one");
    a_pkt_dec_self: assert property (wr_secondary ##1 req_in.rd && req_in.addr == `EMC_OFF_SECONDARY_CONTROL
                                     |=> reg_rdata_out[6] == 1'b0 && reg_rdata_out[4] == 1'b0
                                         && reg_rdata_out[2:0] == 3'h0)  // RULE10 RULE14
        else $error("decrement or unimplemented bits read nonzero");
    a_regulator_gate: assert property (!power_save_out |-> !regulator_low_current_out)  // RULE12
        else $error("low-current regulator without power save");
    a_revision_fixed: assert property (req_in.rd && hit(full_addr, `EMC_OFF_REVISION)
                                       |=> reg_rdata_out == {3'h0, REVISION_ID})  // RULE17
        else $error("revision read changed");
    a_clock_ready_kept: assert property (clock_ready_flag_out |=> clock_ready_flag_out)  // RULE16
        else $error("clock ready flag dropped");

    // primary bit resets and gating
    a_tx_reset_drop: assert property (primary_control.tx_reset && !wr_primary |=> !primary_out.tx_request)  // RULE1
        else $error("transmit request survived reset");
    a_rx_reset_gate: assert property (primary_control.rx_reset |-> !rx_store_packet_out)  // RULE2
        else $error("packet stored in receive reset");
    a_dma_mode_load: assert property (wr_primary |=> primary_out.dma_checksum == $past(req_in.wdata[4]))  // RULE4
        else $error("dma mode bit not loaded");

    // bits of secondary that always read zero
    a_secondary_zero: assert property ((secondary_control & 8'h57) == 8'h00)  // RULE10 RULE14
        else $error("secondary holds a zero bit");

    // stored packets are counted
    a_pkt_count_up: assert property (rx_store_packet_out && !pkt_dec && pending_packet_counter_out != 8'hFF
                                     |=> pending_packet_counter_out ==
                                         $past(pending_packet_counter_out) + 8'h01)  // RULE6
        else $error("stored packet not counted");

    // high byte starts the management write
    a_mgmt_start: assert property (wr_common && hit(full_addr, `EMC_OFF_MGMT_WR_HIGH) |=> mgmt_write_start_out)
        else $error("management write not started");

    // kept over soft reset, so only power-on reset disables these
    a_clock_out_kept: assert property (@(posedge clk_sys_in) disable iff (rst_in)
                                       soft_reset_in && !wr_common |=> $stable(clock_out_control_out))  // RULE15
        else $error("clock-out control lost");
    a_ready_kept: assert property (@(posedge clk_sys_in) disable iff (rst_in)
                                   soft_reset_in && !clock_ready_in |=> $stable(clock_ready_flag_out))  // RULE16
        else $error("clock-ready flag lost");

    c_dma_run: cover property (wr_primary && req_in.wdata[5] ##[1:20] dma_done_in);
    c_tx_run: cover property (wr_primary && req_in.wdata[3] ##[1:20] tx_done_in);
    c_pkt_in_out: cover property (rx_store_packet_out ##[1:20] pkt_dec);
    c_bank_three: cover property (primary_control.bank_select == 2'h3 && req_in.rd);
    c_soft_keeps: cover property (@(posedge clk_sys_in) disable iff (rst_in) soft_reset_in && clock_ready_flag_out);

endmodule

// ===== tb/emc_engine_model.sv
// engine model: buffer bytes plus dma and transmit completion pulses
`timescale 1ns/1ps
module emc_engine_model
    import emc_pkg::*;
(
    // clock and engine controls
    input  wire logic         clk_sys_in,
    input  wire emc_primary_s primary_in,
    input  wire logic [12:0]  rd_ptr_in,
    // engine answers
    output logic [7:0]        rdata_out,
    output logic              dma_done_out,
    output logic              tx_done_out
);
    logic [3:0] cnt;
    // byte depends on the address so a stale pointer shows up
    assign rdata_out = rd_ptr_in[7:0] ^ 8'h5A;
    // dma finishes first, transmit later, both only while started
    always_ff @(posedge clk_sys_in) begin
        cnt          <= (primary_in.dma_busy | primary_in.tx_request) ? cnt + 4'h1 : 4'h0;
        dma_done_out <= primary_in.dma_busy && cnt == 4'h3;
        tx_done_out  <= primary_in.tx_request && cnt == 4'h6;
    end
endmodule

// ===== tb/emc_ctrl_regs_tb.sv
// self-checking bench of the control register bank
`timescale 1ns/1ps
module emc_ctrl_regs_tb;
    import emc_pkg::*;
    localparam logic [4:0] REV = 5'h0A;  // arbitrary value
    logic         clk_sys_in, rst_in, soft_reset_in, rx_packet_in, pass, crdy, rd_seen;
    logic         dma_done, tx_done, store, psave, vlow, cready;
    emc_req_s     req;
    emc_primary_s pri;
    logic [7:0]   rdata, bdata, cnt;
    logic [12:0]  rptr, wptr;
    logic [2:0]   cout;
    logic [15:0]  mrd;
    logic [31:0]  seed;
    logic [7:0]   exp_q[$];
    int           n_fail, num_checks, i;

    emc_ctrl_regs #(.REVISION_ID(REV)) i_emc_ctrl_regs (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .soft_reset_in(soft_reset_in), .req_in(req),
        .reg_rdata_out(rdata), .buffer_rdata_in(bdata), .buffer_rd_out(), .buffer_wr_out(),
        .buffer_wdata_out(), .buffer_read_pointer_out(rptr), .buffer_write_pointer_out(wptr),
        .dma_done_in(dma_done), .tx_done_in(tx_done), .rx_packet_in(rx_packet_in),
        .rx_filter_pass_in(pass), .clock_ready_in(crdy), .mgmt_status_in(8'h00),
        .mgmt_read_data_in(mrd), .selftest_checksum_in(16'h0000), .full_duplex_in(1'b0),
        .primary_out(pri), .rx_store_packet_out(store), .power_save_out(psave),
        .regulator_low_current_out(vlow), .pending_packet_counter_out(cnt), .mgmt_write_start_out(),
        .mgmt_write_data_out(), .station_address_out(), .selftest_seed_out(), .selftest_control_out(),
        .clock_out_control_out(cout), .flow_control_out(), .pause_timer_out(),
        .clock_ready_flag_out(cready));
    emc_engine_model i_emc_engine_model (.clk_sys_in(clk_sys_in), .primary_in(pri), .rd_ptr_in(rptr),
        .rdata_out(bdata), .dma_done_out(dma_done), .tx_done_out(tx_done));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: saw %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // entered at a falling edge; requests may follow back to back
    task automatic xfer(input logic w, input logic [4:0] a, input logic [7:0] d);
        if (!w) exp_q.push_back(d);
        req = '{w, !w, a, w ? d : 8'h00};
        @(negedge clk_sys_in);
    endtask
    task automatic idle(input int n);
        req = '0;
        rx_packet_in = 1'b0;
        repeat (n) @(negedge clk_sys_in);
    endtask
    task automatic pkt(input logic p, input logic keep);
        rx_packet_in = 1'b1;
        pass = p;
        #1 check(store, keep);
        @(negedge clk_sys_in);
    endtask

    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    // read data answers one edge after the read is taken
    always @(posedge clk_sys_in) rd_seen <= req.rd;
    always @(negedge clk_sys_in) begin
        if (rd_seen) check(rdata, exp_q.pop_front());
    end
    // a hang counts as a mismatch
    initial begin
        #1000000 n_fail++;
        stop_test();
    end

    initial begin
        {rst_in, soft_reset_in, req, rx_packet_in, pass, crdy} = '0;
        rst_in = 1'b1;
        seed = 32'h35d9;
        mrd = 16'h0000;
        repeat (4) @(negedge clk_sys_in);
        rst_in = 1'b0;
        check(pri, 8'h00);
        xfer(0, 5'h1D, 8'h80);
        xfer(1, 5'h1C, 8'h03);
        xfer(0, 5'h0C, 8'h04);
        xfer(1, 5'h0B, 8'hFF);
        xfer(0, 5'h0B, {3'h0, REV});
        $display("test reset values done");
        seed = lfsr(lfsr(seed));
        mrd = seed[15:0];
        for (i = 0; i < 4; i++) begin
            xfer(1, 5'h1C, 8'(i));
            xfer(1, 5'h03, 8'h10 + 8'(i));
        end
        for (i = 0; i < 4; i++) begin
            xfer(1, 5'h1C, 8'(i));
            xfer(0, 5'h03, i == 0 ? 8'h10 : i == 1 ? 8'h00 : i == 2 ? mrd[15:8] : 8'h13);
        end
        $display("test bank select done");
        xfer(1, 5'h1C, 8'h00);
        xfer(1, 5'h00, 8'hFE);
        xfer(1, 5'h01, 8'h1F);
        for (i = 0; i < 3; i++) xfer(0, 5'h04, (8'hFE + 8'(i)) ^ 8'h5A);
        xfer(1, 5'h04, 8'hAA);
        idle(1);
        check(rptr, 13'h0001);
        check(wptr, 13'h1001);
        xfer(1, 5'h1D, 8'h00);
        xfer(0, 5'h04, 8'h01 ^ 8'h5A);
        xfer(1, 5'h04, 8'h55);
        idle(1);
        check({rptr, wptr}, {13'h0001, 13'h1001});
        $display("test buffer pointers done");
        xfer(1, 5'h1C, 8'h05);
        idle(1);
        for (i = 0; i < 3; i++) pkt(1, 1);
        pkt(0, 0);
        xfer(1, 5'h1C, 8'h45);
        idle(1);
        pkt(1, 0);
        xfer(1, 5'h1C, 8'h01);
        idle(1);
        pkt(1, 0);
        xfer(0, 5'h09, 8'h03);
        xfer(1, 5'h1D, 8'hC0);
        xfer(0, 5'h1D, 8'h80);
        xfer(0, 5'h09, 8'h02);
        xfer(1, 5'h1D, 8'hEF);
        xfer(0, 5'h1D, 8'hA8);
        idle(1);
        check({cnt, psave, vlow}, {8'h01, 2'b11});
        xfer(1, 5'h1D, 8'h88);
        idle(1);
        check({psave, vlow}, 2'b00);
        $display("test packets and power done");
        xfer(1, 5'h1C, 8'h39);
        idle(1);
        check(pri, 8'h39);
        for (i = 0; i < 40 && (pri.dma_busy || pri.tx_request); i++) @(negedge clk_sys_in);
        check(i < 40, 1'b1);
        check(pri, 8'h11);
        xfer(1, 5'h1C, 8'h88);
        idle(1);
        check(pri, 8'h80);
        $display("test dma and transmit done");
        xfer(1, 5'h1C, 8'h03);
        xfer(1, 5'h0C, 8'h02);
        crdy = 1'b1;
        idle(1);
        crdy = 1'b0;
        soft_reset_in = 1'b1;
        idle(2);
        soft_reset_in = 1'b0;
        check({cout, cready, pri}, {3'h2, 1'b1, 8'h00});
        rst_in = 1'b1;
        idle(1);
        rst_in = 1'b0;
        check({cout, cready}, {3'h4, 1'b0});
        $display("test reset kinds done");
        stop_test();
    end
endmodule
